// ### core/ext_area_bus.sv
// external area bus interface: area decode, selects, strobes and waits
// assumes an internal master that holds its request until done_o
// and a wait pin driven asynchronously by the far side
//
// Summary of operation
// - eight equal areas, size set by mode
// - ram disabled space uses area 7 settings
// - gap before registers uses area 7
// - active-low selects for areas 0 to 3
// - selects decoded from address outputs
// - select driven only when direction bit set
// - rom access: select 0 low, strobes high
// - per-area width, states, wait settings
// - two-state area: two states, no waits
// - three-state area: waits by area enable and shared mode
// - 8-bit area uses upper lane only
// - 16-bit area: even upper, odd lower
// - one read strobe, split write strobes
// - low write strobe high on 8-bit area
// - unused byte lane carries undefined data
// - unused read lane is input, ignored
// - width bit 0 is 16-bit, 1 8-bit
// - state bit 0 two-state, 1 three-state
// - wait enable and shared mode pick wait
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ext_area_bus
  import ext_bus_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  // internal master
  input  wire logic        req_i,
  input  wire logic        write_i,
  input  wire logic        word_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [15:0] wdata_i,
  output logic [15:0]      rdata_o,
  output logic             done_o,
  // external pins
  output logic [23:0]      ext_addr_o,
  output logic [3:0]       area_select_n_o,
  output logic [3:0]       area_select_oe_o,
  output logic             address_strobe_n_o,
  output logic             read_strobe_n_o,
  output logic             high_write_strobe_n_o,
  output logic             low_write_strobe_n_o,
  output logic [15:0]      data_o,
  output logic [1:0]       data_oe_o,
  input  wire logic [15:0] data_i,
  input  wire logic        wait_n_i
);
  // *************************************
  // state and registers
  // *************************************
  typedef enum {ST_IDLE, ST_T1, ST_T2, ST_TW, ST_T3} bus_state_e;
  bus_state_e  state;

  // settings written over the register port
  logic [7:0]  area_width_select;
  logic [7:0]  area_state_select;
  logic [7:0]  area_wait_enable;
  logic [3:0]  wait_setup;
  logic [1:0]  system_setup;
  logic [3:0]  sel_dir;

  // wait pin after the synchroniser
  logic [1:0]  wait_sync;
  logic        wait_pin_n;

  // decode and steering results for the current address
  logic [2:0]  area;
  logic        onchip_rom;
  logic        onchip;
  logic        byte_bus;
  logic        three_state;
  eff_wait_e   wait_kind;
  logic [15:0] out_data;
  logic        use_hi;
  logic        use_lo;
  logic [15:0] steer_rdata;

  // access sequencing
  logic [1:0]  wait_cnt;
  logic        rom_cycle;
  logic        next_extra;
  logic [1:0]  wait_count;
  logic        last_fixed;
  logic        take;
  logic        release_pins;
  logic [3:0]  sel_hit;

  assign wait_count = wait_setup[WCOUNT_LSB +: 2];
  assign last_fixed = (wait_cnt == 2'h1);

  // *************************************
  // decode and steering
  // *************************************
  // decode is combinational, so addr_i must stay put until done_o
  area_decode u_decode (
    .addr_i             (addr_i),
    .mode16m_i          (system_setup[MODE16M_BIT]),
    .ram_en_i           (system_setup[ONCHIP_RAM_ENABLE_BIT]),
    .width_sel_i        (area_width_select),
    .state_sel_i        (area_state_select),
    .wait_en_i          (area_wait_enable),
    .shared_wait_mode_i (wait_setup[WMODE_LSB +: 2]),
    .area_o             (area),
    .onchip_rom_o       (onchip_rom),
    .onchip_o           (onchip),
    .byte_bus_o         (byte_bus),
    .three_state_o      (three_state),
    .wait_kind_o        (wait_kind)
  );

  lane_steer u_steer (
    .byte_bus_i (byte_bus),
    .word_i     (word_i),
    .odd_i      (addr_i[0]),
    .wdata_i    (wdata_i),
    .pin_data_i (data_i),
    .out_data_o (out_data),
    .use_hi_o   (use_hi),
    .use_lo_o   (use_lo),
    .rdata_o    (steer_rdata)
  );

  // *************************************
  // wait pin synchroniser
  // *************************************
  // only the second flop feeds logic, the first may be metastable
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wait_sync <= 2'b11;
    end else begin
      wait_sync <= {wait_sync[0], wait_n_i};
    end
  end
  assign wait_pin_n = wait_sync[1];

  // *************************************
  // register port
  // *************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      area_width_select <= RST_WIDTH_SEL;
      area_state_select <= RST_STATE_SEL;
      area_wait_enable  <= RST_WAIT_EN;
      wait_setup        <= RST_WAIT_SETUP[3:0];
      system_setup      <= RST_SYSTEM[1:0];
      sel_dir           <= RST_SEL_DIR;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_WIDTH_SEL) begin
        area_width_select <= reg_wdata_i;
      end else if (reg_addr_i == ADDR_STATE_SEL) begin
        area_state_select <= reg_wdata_i;
      end else if (reg_addr_i == ADDR_WAIT_SETUP) begin
        wait_setup <= reg_wdata_i[3:0];
      end else if (reg_addr_i == ADDR_WAIT_EN) begin
        area_wait_enable <= reg_wdata_i;
      end else if (reg_addr_i == ADDR_SYSTEM) begin
        system_setup <= reg_wdata_i[1:0];
      end else if (reg_addr_i == ADDR_SEL_DIR) begin
        sel_dir <= reg_wdata_i[3:0];
      end
    end
  end

  // *************************************
  // register reads
  // *************************************
  // idle cycles read zero so stale data never lingers on the port
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == ADDR_WIDTH_SEL) begin
        reg_rdata_o <= area_width_select;
      end else if (reg_addr_i == ADDR_STATE_SEL) begin
        reg_rdata_o <= area_state_select;
      end else if (reg_addr_i == ADDR_WAIT_SETUP) begin
        reg_rdata_o <= WAIT_SETUP_RSVD | {4'h0, wait_setup};
      end else if (reg_addr_i == ADDR_WAIT_EN) begin
        reg_rdata_o <= area_wait_enable;
      end else if (reg_addr_i == ADDR_SYSTEM) begin
        reg_rdata_o <= {6'h00, system_setup};
      end else if (reg_addr_i == ADDR_SEL_DIR) begin
        reg_rdata_o <= {4'h0, sel_dir};
      end else if (reg_addr_i == ADDR_STATUS) begin
        reg_rdata_o <= {1'b0, state != ST_IDLE, wait_pin_n,
                        area, byte_bus, three_state};
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // *************************************
  // access sequencer
  // *************************************
  // waits sampled in t2 or last wait state; extra waits by pin
  always_comb begin
    next_extra = 1'b0;
    case (wait_kind)
      WM_PIN0:  next_extra = !wait_pin_n;
      WM_PIN_1: next_extra = !wait_pin_n;
      default:  next_extra = 1'b0;
    endcase
  end

  // *************************************
  // access state machine
  // *************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state     <= ST_IDLE;
      wait_cnt  <= 2'h0;
      rom_cycle <= 1'b0;
      done_o    <= 1'b0;
      rdata_o   <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          // onchip ram and registers are not this block's business
          if (take) begin
            rom_cycle <= onchip_rom;
            state     <= ST_T1;
          end
        end
        ST_T1: begin
          state <= ST_T2;
        end
        ST_T2: begin
          if (!three_state || rom_cycle) begin
            rdata_o <= steer_rdata;
            done_o  <= 1'b1;
            state   <= ST_IDLE;
          end else if (wait_kind == WM_PROGRAM && wait_count != 2'h0) begin
            wait_cnt <= wait_count;
            state    <= ST_TW;
          end else if (wait_kind == WM_PIN_1 && wait_count != 2'h0) begin
            wait_cnt <= wait_count;
            state    <= ST_TW;
          end else if (wait_kind == WM_AUTOWAIT && !wait_pin_n
                       && wait_count != 2'h0) begin
            wait_cnt <= wait_count;
            state    <= ST_TW;
          end else if (next_extra) begin
            wait_cnt <= 2'h0;
            state    <= ST_TW;
          end else begin
            state <= ST_T3;
          end
        end
        ST_TW: begin
          if (wait_cnt > 2'h1) begin
            wait_cnt <= wait_cnt - 2'h1;
          end else if ((wait_cnt == 2'h0 || last_fixed) && next_extra) begin
            wait_cnt <= 2'h0;
          end else begin
            wait_cnt <= 2'h0;
            state    <= ST_T3;
          end
        end
        default: begin
          rdata_o <= steer_rdata;
          done_o  <= 1'b1;
          state   <= ST_IDLE;
        end
      endcase
    end
  end

  // *************************************
  // pin drivers
  // *************************************
  // one take condition shared so strobes and sequencer never disagree
  assign take = (state == ST_IDLE) && req_i && !done_o
                && (!onchip || onchip_rom);
  // pins drop back at the edge that raises done_o
  assign release_pins = (state == ST_T2 && (!three_state || rom_cycle))
                        || (state == ST_T3);

  // one decoder per select pin; areas 4 to 7 hit none of them
  for (genvar g = 0; g < 4; g++) begin : g_sel
    assign sel_hit[g] = (area == 3'(g));
  end

  // address and data held from take until the next access
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ext_addr_o <= 24'h000000;
      data_o     <= 16'h0000;
    end else if (take) begin
      ext_addr_o <= addr_i;
      data_o     <= out_data;
    end
  end

  // strobes registered one state ahead so pins come from flops
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      area_select_n_o       <= 4'hf;
      area_select_oe_o      <= RST_SEL_DIR;
      address_strobe_n_o    <= 1'b1;
      read_strobe_n_o       <= 1'b1;
      high_write_strobe_n_o <= 1'b1;
      low_write_strobe_n_o  <= 1'b1;
      data_oe_o             <= 2'b00;
    end else begin
      area_select_oe_o <= sel_dir;
      if (take) begin
        // on-chip rom keeps select 0 but none of the strobes
        area_select_n_o       <= ~sel_hit;
        address_strobe_n_o    <= onchip_rom;
        read_strobe_n_o       <= onchip_rom || write_i;
        high_write_strobe_n_o <= onchip_rom || !write_i || !use_hi;
        low_write_strobe_n_o  <= onchip_rom || !write_i || !use_lo
                                 || byte_bus;
        data_oe_o <= (write_i && !onchip_rom) ?
                     {1'b1, !byte_bus} : 2'b00;
      end else if (release_pins) begin
        area_select_n_o       <= 4'hf;
        address_strobe_n_o    <= 1'b1;
        read_strobe_n_o       <= 1'b1;
        high_write_strobe_n_o <= 1'b1;
        low_write_strobe_n_o  <= 1'b1;
        data_oe_o             <= 2'b00;
      end
    end
  end
endmodule
`default_nettype wire

// ### core/ext_bus_pkg.sv
// constants shared by the external area bus interface
// assumes nothing beyond a systemverilog compiler
package ext_bus_pkg;
  // *************************************
  // register map (plain port, byte wide)
  // *************************************
  localparam logic [3:0] ADDR_WIDTH_SEL  = 4'h0;
  localparam logic [3:0] ADDR_STATE_SEL  = 4'h1;
  localparam logic [3:0] ADDR_WAIT_SETUP = 4'h2;
  localparam logic [3:0] ADDR_WAIT_EN    = 4'h3;
  localparam logic [3:0] ADDR_SYSTEM     = 4'h4;
  localparam logic [3:0] ADDR_SEL_DIR    = 4'h5;
  localparam logic [3:0] ADDR_STATUS     = 4'h6;
  // *************************************
  // reset values
  // *************************************
  localparam logic [7:0] RST_WIDTH_SEL   = 8'hff;
  localparam logic [7:0] RST_STATE_SEL   = 8'hff;
  localparam logic [7:0] RST_WAIT_SETUP  = 8'hf3;
  localparam logic [7:0] RST_WAIT_EN     = 8'hff;
  localparam logic [7:0] RST_SYSTEM      = 8'h01;
  localparam logic [3:0] RST_SEL_DIR     = 4'h1;
  localparam logic [7:0] WAIT_SETUP_RSVD = 8'hf0;
  // *************************************
  // field positions
  // *************************************
  localparam int WMODE_LSB   = 2;
  localparam int WCOUNT_LSB  = 0;
  localparam int ONCHIP_RAM_ENABLE_BIT    = 0;
  localparam int MODE16M_BIT = 1;
  // *************************************
  // address map, 24-bit internal address
  // *************************************
  localparam logic [23:0] ROM_TOP    = 24'h00ffff;
  localparam logic [23:0] RAM_BASE   = 24'hfff000;
  localparam logic [23:0] RAM_TOP    = 24'hfff7ff;
  localparam logic [23:0] REG_BASE   = 24'hffff00;
  localparam logic [23:0] ADDR1M_MSK = 24'h0fffff;
  // *************************************
  // enumerations
  // *************************************
  typedef enum logic [1:0] {
    WM_PROG, WM_NONE, WM_PIN1, WM_AUTO
  } wait_mode_e;
  typedef enum logic [2:0] {
    WM_OFF, WM_PIN0, WM_PROGRAM, WM_PIN_1, WM_AUTOWAIT
  } eff_wait_e;
endpackage

// ### core/area_decode.sv
// decodes the active area and its bus settings from one address
// assumes a 24-bit address and eight-bit per-area setting vectors
`timescale 1ns/1ps
`default_nettype none
module area_decode
  import ext_bus_pkg::*;
(
  // address and mode
  input  wire logic [23:0] addr_i,
  input  wire logic        mode16m_i,
  input  wire logic        ram_en_i,
  // per-area settings
  input  wire logic [7:0]  width_sel_i,
  input  wire logic [7:0]  state_sel_i,
  input  wire logic [7:0]  wait_en_i,
  input  wire logic [1:0]  shared_wait_mode_i,
  // decoded result
  output logic [2:0]       area_o,
  output logic             onchip_rom_o,
  output logic             onchip_o,
  output logic             byte_bus_o,
  output logic             three_state_o,
  output eff_wait_e        wait_kind_o
);
  logic in_ram;
  logic in_reg;
  logic in_rom;
  logic [23:0] top_addr;

  always_comb begin
    // area from top three bits of the active space
    area_o = mode16m_i ? addr_i[23:21] : addr_i[19:17];
    in_rom = (addr_i & (mode16m_i ? 24'hffffff : ADDR1M_MSK)) <= ROM_TOP;
    // only the small space ignores the upper nibble, so fold it there only
    top_addr = mode16m_i ? addr_i : (addr_i | ~ADDR1M_MSK);
    in_ram = ram_en_i && (top_addr >= RAM_BASE)
             && (top_addr <= RAM_TOP);
    in_reg = top_addr >= REG_BASE;
    // gap between ram and registers falls into area 7 by its address
    if (top_addr >= RAM_BASE) begin
      area_o = 3'h7;
    end
    onchip_rom_o  = in_rom && !mode16m_i;
    onchip_o      = in_ram || in_reg || onchip_rom_o;
    byte_bus_o    = width_sel_i[area_o];
    three_state_o = state_sel_i[area_o];
    if (!three_state_o) begin
      wait_kind_o = WM_OFF;
    end else if (!wait_en_i[area_o]) begin
      wait_kind_o = WM_PIN0;
    end else begin
      case (wait_mode_e'(shared_wait_mode_i))
        WM_PROG: wait_kind_o = WM_PROGRAM;
        WM_NONE: wait_kind_o = WM_OFF;
        WM_PIN1: wait_kind_o = WM_PIN_1;
        default: wait_kind_o = WM_AUTOWAIT;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### core/lane_steer.sv
// steers bytes between the internal bus and the two external lanes
// assumes settings held stable for the whole access
`timescale 1ns/1ps
`default_nettype none
module lane_steer
  import ext_bus_pkg::*;
(
  // access description
  input  wire logic        byte_bus_i,
  input  wire logic        word_i,
  input  wire logic        odd_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [15:0] pin_data_i,
  // steered result
  output logic [15:0]      out_data_o,
  output logic             use_hi_o,
  output logic             use_lo_o,
  output logic [15:0]      rdata_o
);
  always_comb begin
    use_hi_o = 1'b1;
    use_lo_o = 1'b0;
    out_data_o = {wdata_i[7:0], wdata_i[7:0]};
    rdata_o = 16'h0000;
    if (byte_bus_i) begin
      rdata_o = {8'h00, pin_data_i[15:8]};
    end else if (word_i) begin
      use_lo_o = 1'b1;
      out_data_o = wdata_i;
      rdata_o = pin_data_i;
    end else if (odd_i) begin
      use_hi_o = 1'b0;
      use_lo_o = 1'b1;
      rdata_o = {8'h00, pin_data_i[7:0]};
    end else begin
      rdata_o = {8'h00, pin_data_i[15:8]};
    end
  end
endmodule
`default_nettype wire

// ### sim/ext_area_bus_checker.sv
// assertions for the external area bus interface
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ext_area_bus_checker
  import ext_bus_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        req_i,
  input wire logic [23:0] addr_i,
  input wire logic        done_o,
  input wire logic [23:0] ext_addr_o,
  input wire logic [3:0]  area_select_n_o,
  input wire logic [3:0]  area_select_oe_o,
  input wire logic        address_strobe_n_o,
  input wire logic        read_strobe_n_o,
  input wire logic        high_write_strobe_n_o,
  input wire logic        low_write_strobe_n_o,
  input wire logic [1:0]  data_oe_o
);
  // shadows, since the settings are not visible at the pins
  logic [7:0] wid;
  logic [7:0] ast;
  logic       m16;
  logic [2:0] ea;
  logic [2:0] ra;
  logic [3:0] esel;
  logic       rom;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wid <= RST_WIDTH_SEL;
      ast <= RST_STATE_SEL;
      m16 <= RST_SYSTEM[MODE16M_BIT];
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_WIDTH_SEL) wid <= reg_wdata_i;
      if (reg_addr_i == ADDR_STATE_SEL) ast <= reg_wdata_i;
      if (reg_addr_i == ADDR_SYSTEM) m16 <= reg_wdata_i[MODE16M_BIT];
    end
  end
  assign ea = m16 ? ext_addr_o[23:21] : ext_addr_o[19:17];
  assign ra = m16 ? addr_i[23:21] : addr_i[19:17];
  assign esel = ea[2] ? 4'hf : ~(4'h1 << ea[1:0]);
  assign rom = !m16 && addr_i <= ROM_TOP;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_hold2;
    !done_o [*2];
  endsequence
  sequence s_hold3;
    !done_o [*3];
  endsequence
  property p_dir;
    disable iff (1'b0) rst_i |=> area_select_oe_o == RST_SEL_DIR;
  endproperty
  property p_two;
    $rose(req_i) && !ast[ra] |=> s_hold2 ##1 done_o;
  endproperty
  property p_three;
    $rose(req_i) && ast[ra] && !rom |=> s_hold3;
  endproperty
  property p_sel;
    !address_strobe_n_o |-> area_select_n_o == esel;
  endproperty
  property p_one;
    $onehot0(~area_select_n_o);
  endproperty
  property p_rom;
    !area_select_n_o[0] && !m16 && ext_addr_o <= ROM_TOP |->
      address_strobe_n_o && read_strobe_n_o && high_write_strobe_n_o
      && low_write_strobe_n_o;
  endproperty
  property p_low;
    !address_strobe_n_o && wid[ea] |-> low_write_strobe_n_o;
  endproperty
  property p_upper;
    !high_write_strobe_n_o |-> data_oe_o[1];
  endproperty
  property p_rd;
    !read_strobe_n_o |-> data_oe_o == 2'b00 && high_write_strobe_n_o
      && low_write_strobe_n_o;
  endproperty
  a_dir: assert property (p_dir) else $error("direction not reset");
  a_two: assert property (p_two) else $error("two-state length");
  a_three: assert property (p_three) else $error("three-state short");
  a_sel: assert property (p_sel) else $error("select decode");
  a_one: assert property (p_one) else $error("several selects");
  a_rom: assert property (p_rom) else $error("strobe in rom access");
  a_low: assert property (p_low) else $error("low strobe on 8-bit");
  a_upper: assert property (p_upper) else $error("upper lane idle");
  a_rd: assert property (p_rd) else $error("lane driven on read");
endmodule
`default_nettype wire

// ### sim/ext_mem_model.sv
// byte memory standing on the external bus
// assumes byte addresses and active-low strobes from the block
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input  wire logic        mclk_i,
  input  wire logic [23:0] ext_addr_i,
  input  wire logic        read_strobe_n_i,
  input  wire logic        high_write_strobe_n_i,
  input  wire logic        low_write_strobe_n_i,
  input  wire logic [15:0] pin_i,
  output logic      [15:0] pin_o
);
  logic [7:0]  mem [256];
  logic [15:0] last = 16'h5a5a;
  logic [7:0]  a;
  assign a = ext_addr_i[7:0];
  // released lanes show the inverse, so stale data never passes
  always_comb begin
    if (!read_strobe_n_i) pin_o = {mem[a], mem[a | 8'h01]};
    else pin_o = ~last;
  end
  always @(posedge mclk_i) begin
    if (!read_strobe_n_i) last <= pin_o;
    if (!high_write_strobe_n_i) mem[a] <= pin_i[15:8];
    if (!low_write_strobe_n_i) mem[a | 8'h01] <= pin_i[7:0];
  end
endmodule
`default_nettype wire

// ### sim/ext_area_bus_test.sv
// self-checking bench for the external area bus interface
// assumes the byte memory model as the far side
`timescale 1ns/1ps
`default_nettype none
module ext_area_bus_test;
  import ext_bus_pkg::*;
  typedef struct {logic [15:0] d; logic [15:0] m; int lat;} exp_s;
  logic        mclk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o;
  logic        req_i = 0, write_i = 0, word_i = 0, wait_n_i = 1, rd_d = 0;
  logic [23:0] addr_i = 24'h0, ext_addr_o;
  logic [15:0] wdata_i = 16'h0, rdata_o, data_o, data_i, mdat;
  logic [3:0]  area_select_n_o, area_select_oe_o;
  logic [1:0]  data_oe_o;
  logic        done_o, address_strobe_n_o, read_strobe_n_o;
  logic        high_write_strobe_n_o, low_write_strobe_n_o;
  logic [7:0]  ast = RST_STATE_SEL, wid = RST_WIDTH_SEL;
  int          error_cnt = 0, checked = 0, cnt = 0, cyc = 0, xw = 0;
  exp_s        aq[$];
  logic [7:0]  rq[$];
  ext_area_bus u_ext_area_bus (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .req_i, .write_i, .word_i, .addr_i,
    .wdata_i, .rdata_o, .done_o, .ext_addr_o, .area_select_n_o,
    .area_select_oe_o, .address_strobe_n_o, .read_strobe_n_o,
    .high_write_strobe_n_o, .low_write_strobe_n_o, .data_o, .data_oe_o,
    .data_i, .wait_n_i);
  ext_mem_model u_ext_mem_model (.mclk_i, .ext_addr_i(ext_addr_o),
    .read_strobe_n_i(read_strobe_n_o), .pin_i(data_i), .pin_o(mdat),
    .high_write_strobe_n_i(high_write_strobe_n_o),
    .low_write_strobe_n_i(low_write_strobe_n_o));
  assign data_i = {data_oe_o[1] ? data_o[15:8] : mdat[15:8],
                   data_oe_o[0] ? data_o[7:0] : mdat[7:0]};
  initial forever #5 mclk_i = ~mclk_i;
  task automatic chk(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // strobes stay up between calls so no signal is assigned twice per step
  task automatic rg(input logic w, input logic [3:0] a, input logic [7:0] d);
    if (!w) rq.push_back(d);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
  endtask
  task automatic acc(input logic w, wd, input logic [23:0] a,
                     input logic [15:0] d, m, input int lat);
    aq.push_back('{d & m, m, lat});
    reg_wr_i <= 0;
    reg_rd_i <= 0;
    req_i <= 1;
    write_i <= w;
    word_i <= wd;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i iff done_o === 1'b1);
    req_i <= 0;
    @(posedge mclk_i);
  endtask
  function automatic int lat(input int n);
    return ast[n] ? 4 + xw : 3;
  endfunction
  always @(posedge mclk_i) begin
    exp_s e;
    cyc++;
    if (rd_d) chk("reg", {8'h0, reg_rdata_o}, {8'h0, rq.pop_front()});
    rd_d = reg_rd_i;
    if (done_o === 1'b1) begin
      e = aq.pop_front();
      chk("rdata", rdata_o & e.m, e.d);
      chk("latency", 16'(cnt), 16'(e.lat));
      cnt = 0;
    end else if (req_i) cnt++;
    // far above the few hundred cycles the sequence needs
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    logic [23:0] a;
    logic [15:0] d, b;
    logic [7:0]  rv [7] = '{8'hff, 8'hff, 8'hf3, 8'hff, 8'h01, 8'h01, 8'h00};
    void'($urandom(32'hc7fcd434));
    repeat (5) @(posedge mclk_i);
    rst_i <= 0;
    @(posedge mclk_i);
    for (int i = 0; i < 7; i++) rg(0, i < 6 ? 4'(i) : 4'hf, rv[i]);
    rg(1, ADDR_WAIT_SETUP, 8'h00);
    rg(1, 4'hf, 8'h5a);
    rg(0, ADDR_WAIT_SETUP, WAIT_SETUP_RSVD);
    rg(0, 4'hf, 8'h00);
    rg(0, ADDR_STATUS, 8'h23);
    wid = 8'hfa;
    ast = 8'hf3;
    xw = 3;
    rg(1, ADDR_WIDTH_SEL, wid);
    rg(1, ADDR_STATE_SEL, ast);
    rg(1, ADDR_SEL_DIR, 8'h0f);
    rg(1, ADDR_WAIT_SETUP, 8'h03);
    for (int n = 0; n < 8; n++) begin
      a = (24'(n) << 17) + 24'h010040;
      d = 16'($urandom);
      b = 16'($urandom);
      if (wid[n]) begin
        acc(1, 0, a | 24'h1, d, 16'h0, lat(n));
        acc(0, 0, a | 24'h1, d, 16'h00ff, lat(n));
      end else begin
        acc(1, 1, a, d, 16'h0, lat(n));
        acc(1, 0, a | 24'h1, b, 16'h0, lat(n));
        acc(0, 1, a, {d[15:8], b[7:0]}, 16'hffff, lat(n));
        acc(0, 0, a, {8'h0, d[15:8]}, 16'h00ff, lat(n));
      end
    end
    chk("dir", {12'h0, area_select_oe_o}, 16'h000f);
    for (int k = 0; k < 4; k++) begin
      b = 16'($urandom_range(3));
      rg(1, ADDR_WAIT_SETUP, 8'(k * 4) | b[7:0]);
      xw = (k % 2 == 0) ? int'(b) : 0;
      acc(0, 0, 24'h020080, 16'h0, 16'h0, lat(1));
    end
    rg(1, ADDR_WAIT_EN, 8'hfd);
    rg(1, ADDR_WAIT_SETUP, 8'h0b);
    xw = 0;
    acc(0, 0, 24'h020080, 16'h0, 16'h0, lat(1));
    xw = 3;
    wait_n_i <= 0;
    repeat (3) @(posedge mclk_i);
    acc(1, 0, 24'h040090, d, 16'h0, 3);
    rg(1, ADDR_WAIT_SETUP, 8'h0d);
    acc(0, 0, 24'h0a0080, 16'h0, 16'h0, 5);
    wait_n_i <= 1;
    repeat (3) @(posedge mclk_i);
    rg(1, ADDR_WAIT_SETUP, 8'h0b);
    acc(0, 0, 24'h000100, 16'h0, 16'h0, 3);
    acc(1, 0, 24'hfff900, b, 16'h0, lat(7));
    acc(0, 0, 24'hfff900, b, 16'h00ff, lat(7));
    rg(1, ADDR_SYSTEM, 8'h00);
    acc(1, 0, 24'hfff010, d, 16'h0, lat(7));
    acc(0, 0, 24'hfff010, d, 16'h00ff, lat(7));
    rg(1, ADDR_SYSTEM, 8'h03);
    acc(1, 0, 24'h400041, b, 16'h0, lat(2));
    acc(0, 0, 24'h400041, b, 16'h00ff, lat(2));
    acc(0, 0, 24'h0ff040, 16'h0, 16'h0, lat(0));
    acc(0, 0, 24'h200050, 16'h0, 16'h0, 4);
    results();
  end
endmodule
bind ext_area_bus ext_area_bus_checker u_ext_area_bus_checker (
  .mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .req_i, .addr_i,
  .done_o, .ext_addr_o, .area_select_n_o, .area_select_oe_o,
  .address_strobe_n_o, .read_strobe_n_o, .high_write_strobe_n_o,
  .low_write_strobe_n_o, .data_oe_o);
`default_nettype wire
